// file: verilog/dirb_core.sv
// Slave-side readback sequencer of a quad 12-bit converter on a two-wire bus.
// Assumes scl and sda levels arrive synchronous to i_clk and far slower than it;
// the write path outside this block loads channel words over the load port.
// ----------------------------------------------------------------
// ----------------------------------------------------------------
`timescale 1ns/100ps
`default_nettype none
module dirb_core
	import dirb_pkg::*;
#(
	parameter int CHANNELS = DIRB_CHANNELS
) (
	input wire logic i_clk,
	input wire logic i_reset_n,
	input wire logic i_scl,
	input wire logic i_sda,
	output logic o_sda_out,
	output logic o_sda_oe,
	input wire logic i_hw_address_hi,
	input wire logic i_hw_address_lo,
	input wire logic i_load_valid,
	input wire logic [1:0] i_load_channel,
	input wire logic [11:0] i_load_data,
	input wire logic [1:0] i_load_mode,
	output logic [1:0] o_channel_sel,
	output logic o_power_down_flag,
	output logic o_busy
);
	// ----------------------------------------------------------------
	// Pin sampling and bus conditions
	// ----------------------------------------------------------------
	logic scl_q, sda_q, scl_p_q, sda_p_q;
	always_ff @(posedge i_clk) begin
		if (!i_reset_n) begin
			scl_q <= 1'b1;
			sda_q <= 1'b1;
			scl_p_q <= 1'b1;
			sda_p_q <= 1'b1;
		end else begin
			scl_q <= i_scl;
			sda_q <= i_sda;
			scl_p_q <= scl_q;
			sda_p_q <= sda_q;
		end
	end
	wire scl_rise = scl_q & ~scl_p_q;
	wire scl_fall = ~scl_q & scl_p_q;
	wire start_seen = scl_q & scl_p_q & sda_p_q & ~sda_q;
	wire stop_seen = scl_q & scl_p_q & ~sda_p_q & sda_q;

	// ----------------------------------------------------------------
	// Held channel words
	// ----------------------------------------------------------------
	// Only the load port writes these; the readback path reads them alone
	logic [CHANNELS-1:0][13:0] chan_q;
	genvar g;
	generate
		for (g = 0; g < CHANNELS; g++) begin : g_chan
			always_ff @(posedge i_clk) begin
				if (!i_reset_n) begin
					chan_q[g] <= DIRB_ENTRY_RESET;
				end else if (i_load_valid && (i_load_channel == 2'(g))) begin
					chan_q[g] <= {i_load_mode, i_load_data};
				end
			end
		end
	endgenerate

	// ----------------------------------------------------------------
	// Sequencer registers
	// ----------------------------------------------------------------
	dirb_state_t st_q, st_d;
	logic [3:0] cnt_q;
	logic [7:0] rx_q, tx_q;
	logic rw_q, is_ctrl_q, mack_ok_q, pd_q;
	logic [1:0] sel_q, idx_q;

	wire [13:0] sel_entry = chan_q[sel_q];
	wire [7:0] pd_byte = {sel_entry[DIRB_MODE_MSB:DIRB_MODE_LSB], DIRB_PD_FILL};
	wire [7:0] hi_byte = sel_entry[11:4];
	wire [7:0] lo_byte = {sel_entry[3:0], DIRB_LOW_FILL};
	wire [1:0] byte_count = pd_q ? DIRB_BYTES_PD : DIRB_BYTES_PLAIN;
	wire [1:0] next_idx = (st_q == DIRB_ST_ACK) ? 2'h0 : idx_q + 2'h1;
	wire [7:0] pd_seq_byte = (next_idx == 2'h0) ? pd_byte : (next_idx == 2'h1) ? hi_byte : lo_byte;
	wire [7:0] plain_seq_byte = (next_idx == 2'h0) ? hi_byte : lo_byte;
	wire [7:0] load_byte = pd_q ? pd_seq_byte : plain_seq_byte;
	wire addr_match = rx_q[7:1] == {DIRB_ADDR_PREFIX, i_hw_address_hi, i_hw_address_lo};
	wire byte_done = scl_fall && (cnt_q == DIRB_BITS_PER_BYTE);
	wire more_bytes = (idx_q + 2'h1) < byte_count;

	always_comb begin
		st_d = st_q;
		if (start_seen) begin
			st_d = DIRB_ST_ADDR;
		end else if (stop_seen) begin
			st_d = DIRB_ST_IDLE;
		end else begin
			unique case (st_q)
				DIRB_ST_IDLE, DIRB_ST_WAIT: st_d = st_q;
				DIRB_ST_ADDR: begin
					if (byte_done) begin
						st_d = addr_match ? DIRB_ST_ACK : DIRB_ST_IDLE;
					end
				end
				DIRB_ST_CTRL: begin
					if (byte_done) begin
						st_d = DIRB_ST_ACK;
					end
				end
				DIRB_ST_ACK: begin
					if (scl_fall) begin
						st_d = rw_q ? DIRB_ST_TX : (is_ctrl_q ? DIRB_ST_WAIT : DIRB_ST_CTRL);
					end
				end
				DIRB_ST_TX: begin
					if (scl_fall && cnt_q == DIRB_LAST_TX_BIT) begin
						st_d = DIRB_ST_MACK;
					end
				end
				DIRB_ST_MACK: begin
					if (scl_fall) begin
						st_d = mack_ok_q ? DIRB_ST_TX : DIRB_ST_IDLE;
					end
				end
			endcase
		end
	end

	always_ff @(posedge i_clk) begin
		if (!i_reset_n) begin
			st_q <= DIRB_ST_IDLE;
		end else begin
			st_q <= st_d;
		end
	end

	// Bit counter and receive shifter
	always_ff @(posedge i_clk) begin
		if (!i_reset_n) begin
			cnt_q <= 4'h0;
			rx_q <= 8'h00;
		end else if (start_seen || st_d != st_q) begin
			cnt_q <= 4'h0;
		end else if ((st_q == DIRB_ST_ADDR || st_q == DIRB_ST_CTRL) && scl_rise) begin
			rx_q <= {rx_q[6:0], sda_q};
			cnt_q <= cnt_q + 4'h1;
		end else if (st_q == DIRB_ST_TX && scl_fall) begin
			cnt_q <= cnt_q + 4'h1;
		end
	end

	// Direction, control byte and transmit shifter
	always_ff @(posedge i_clk) begin
		if (!i_reset_n) begin
			rw_q <= 1'b0;
			is_ctrl_q <= 1'b0;
			sel_q <= 2'h0;
			pd_q <= 1'b0;
			idx_q <= 2'h0;
			tx_q <= 8'hff;
			mack_ok_q <= 1'b0;
		end else begin
			if (st_q == DIRB_ST_ADDR && byte_done) begin
				rw_q <= rx_q[DIRB_RW_BIT];
				is_ctrl_q <= 1'b0;
			end
			if (st_q == DIRB_ST_CTRL && byte_done) begin
				sel_q <= rx_q[DIRB_CTRL_SEL_MSB:DIRB_CTRL_SEL_LSB];
				pd_q <= rx_q[DIRB_CTRL_PD_BIT];
				is_ctrl_q <= 1'b1;
			end
			if (st_d == DIRB_ST_TX && st_q != DIRB_ST_TX && !start_seen && !stop_seen) begin
				tx_q <= load_byte;
				idx_q <= next_idx;
			end else if (st_q == DIRB_ST_TX && scl_fall) begin
				tx_q <= {tx_q[6:0], 1'b1};
			end
			if (st_q == DIRB_ST_MACK && scl_rise) begin
				mack_ok_q <= ~sda_q && more_bytes;
			end else if (st_q != DIRB_ST_MACK) begin
				mack_ok_q <= 1'b0;
			end
		end
	end

	// ----------------------------------------------------------------
	// Open-drain drive and status
	// ----------------------------------------------------------------
	// Only ever pulls low; a one is sent by releasing the line
	assign o_sda_out = 1'b0;
	assign o_sda_oe = (st_q == DIRB_ST_ACK) || (st_q == DIRB_ST_TX && !tx_q[7]);
	assign o_channel_sel = sel_q;
	assign o_power_down_flag = pd_q;
	assign o_busy = st_q != DIRB_ST_IDLE;

	// ----------------------------------------------------------------
	// Assertions
	// ----------------------------------------------------------------
	a_addr_ack: assert property (@(posedge i_clk) disable iff (!i_reset_n)
		(st_q == DIRB_ST_ADDR && byte_done && addr_match && !start_seen && !stop_seen) |=> o_sda_oe)
		else $error("address byte not acknowledged");
	a_ctrl_store: assert property (@(posedge i_clk) disable iff (!i_reset_n)
		(st_q == DIRB_ST_CTRL && byte_done && !start_seen && !stop_seen)
		|=> (o_channel_sel == $past(rx_q[2:1])) && o_power_down_flag == $past(rx_q[0]) && o_sda_oe)
		else $error("control byte not captured or acknowledged");
	a_msb_drive: assert property (@(posedge i_clk) disable iff (!i_reset_n)
		(st_q == DIRB_ST_TX && scl_fall && st_d == DIRB_ST_TX) |=> (o_sda_oe == !$past(tx_q[6])))
		else $error("transmit bit not on data line");
	a_first_byte: assert property (@(posedge i_clk) disable iff (!i_reset_n)
		($past(st_q) == DIRB_ST_ACK && st_q == DIRB_ST_TX)
		|-> tx_q == (pd_q ? pd_byte : sel_entry[11:4]))
		else $error("wrong first readback byte");
	a_pd_fill: assert property (@(posedge i_clk) disable iff (!i_reset_n)
		(st_q == DIRB_ST_TX && pd_q && idx_q == 2'h0 && cnt_q == 4'h0)
		|-> tx_q == {sel_entry[13:12], 6'h3f})
		else $error("power-down byte layout wrong");
	a_low_byte: assert property (@(posedge i_clk) disable iff (!i_reset_n)
		(st_q == DIRB_ST_TX && cnt_q == 4'h0 && idx_q == byte_count - 2'h1)
		|-> tx_q[7:4] == sel_entry[3:0])
		else $error("low byte nibble wrong");
	a_mack_release: assert property (@(posedge i_clk) disable iff (!i_reset_n)
		(st_q == DIRB_ST_MACK) |-> !o_sda_oe)
		else $error("data line held in master acknowledge slot");
	a_nack_stops: assert property (@(posedge i_clk) disable iff (!i_reset_n)
		(st_q == DIRB_ST_MACK && scl_rise && sda_q && !start_seen && !stop_seen)
		|=> !mack_ok_q)
		else $error("transmission continued after not-acknowledge");
	a_nack_idle: assert property (@(posedge i_clk) disable iff (!i_reset_n)
		(st_q == DIRB_ST_MACK && scl_fall && !mack_ok_q && !start_seen && !stop_seen)
		|=> (st_q == DIRB_ST_IDLE && !o_sda_oe))
		else $error("device kept the line after the final slot");
	a_no_third: assert property (@(posedge i_clk) disable iff (!i_reset_n)
		(st_q == DIRB_ST_TX && !pd_q) |-> idx_q < 2'h2)
		else $error("more than two bytes without power-down flag");
	a_reset_zero: assert property (@(posedge i_clk)
		$past(!i_reset_n) && i_reset_n |-> chan_q == '0)
		else $error("channel words not zero after reset");
	a_read_keeps: assert property (@(posedge i_clk) disable iff (!i_reset_n)
		!i_load_valid |=> $stable(chan_q))
		else $error("held words changed without a load");
endmodule : dirb_core
`default_nettype wire

// file: verilog/dirb_pkg.sv
// Constants shared by the two-wire readback path of the quad 12-bit converter.
// Assumes a single system clock domain; bus pins are sampled as synchronous inputs.
package dirb_pkg;
	// ----------------------------------------------------------------
	// Addressing and control byte layout
	// ----------------------------------------------------------------
	localparam logic [4:0] DIRB_ADDR_PREFIX = 5'h13;
	localparam int DIRB_RW_BIT = 0;
	localparam int DIRB_CTRL_PD_BIT = 0;
	localparam int DIRB_CTRL_SEL_LSB = 1;
	localparam int DIRB_CTRL_SEL_MSB = 2;
	// ----------------------------------------------------------------
	// Held channel word and readback byte layout
	// ----------------------------------------------------------------
	localparam int DIRB_CHANNELS = 4;
	localparam int DIRB_DATA_W = 12;
	localparam int DIRB_MODE_LSB = 12;
	localparam int DIRB_MODE_MSB = 13;
	localparam logic [13:0] DIRB_ENTRY_RESET = 14'h0000;
	localparam logic [5:0] DIRB_PD_FILL = 6'h3f;
	localparam logic [3:0] DIRB_LOW_FILL = 4'h0;
	localparam logic [1:0] DIRB_BYTES_PLAIN = 2'h2;
	localparam logic [1:0] DIRB_BYTES_PD = 2'h3;
	localparam logic [3:0] DIRB_BITS_PER_BYTE = 4'h8;
	localparam logic [3:0] DIRB_LAST_TX_BIT = 4'h7;
	// ----------------------------------------------------------------
	// Transfer sequencer states
	// ----------------------------------------------------------------
	typedef enum logic [6:0] {
		DIRB_ST_IDLE = 7'h01,
		DIRB_ST_ADDR = 7'h02,
		DIRB_ST_ACK = 7'h04,
		DIRB_ST_CTRL = 7'h08,
		DIRB_ST_WAIT = 7'h10,
		DIRB_ST_TX = 7'h20,
		DIRB_ST_MACK = 7'h40
	} dirb_state_t;
endpackage : dirb_pkg

// file: tb/dirb_master_model.sv
// Behavioural two-wire bus master for the readback sequencer.
// Assumes a pull-up on data: the wire is low while any party drives it.
`timescale 1ns/100ps
`default_nettype none
module dirb_master_model (
	input wire logic i_clk,
	input wire logic i_sda,
	output logic o_scl,
	output logic o_sda_oe
);
	// ----------------------------------------------------------------
	// Bus phases, changed on falling clock edges only
	// ----------------------------------------------------------------
	initial begin
		o_scl = 1'b1;
		o_sda_oe = 1'b0;
	end
	task automatic hold(input int n);
		repeat (n) @(negedge i_clk);
	endtask : hold
	// Also a repeated start: data let go while the clock is low
	task automatic start();
		hold(4);
		o_sda_oe = 1'b0;
		hold(4);
		o_scl = 1'b1;
		hold(6);
		o_sda_oe = 1'b1;
		hold(6);
		o_scl = 1'b0;
	endtask : start
	task automatic stop();
		hold(4);
		o_sda_oe = 1'b1;
		hold(4);
		o_scl = 1'b1;
		hold(6);
		o_sda_oe = 1'b0;
		hold(6);
	endtask : stop
	// Eight bits and the ninth slot; a one lets the line go
	task automatic xfer(input logic [8:0] tx, output logic [8:0] rx);
		for (int i = 8; i >= 0; i--) begin
			hold(4);
			o_sda_oe = ~tx[i];
			hold(4);
			o_scl = 1'b1;
			hold(6);
			rx[i] = i_sda;
			o_scl = 1'b0;
		end
	endtask : xfer
endmodule : dirb_master_model
`default_nettype wire

// file: tb/dirb_core_tb.sv
// Self-checking bench for the readback sequencer and its bus master model.
// Assumes a pull-up on the data line; straps fixed at hi=1, lo=0.
`timescale 1ns/100ps
`default_nettype none
`define CHK(nm, gt, ex) begin compares++; if ((gt) !== (ex)) begin fail_count++; \
	$display("CHECK FAILED %s expected %h seen %h", nm, ex, gt); end end
module dirb_core_tb
	import dirb_pkg::*;
();
	typedef struct packed {logic [1:0] ch; logic pd; logic [23:0] exp;} dirb_row_t;
	logic clk = 1'b0;
	logic rst_n = 1'b0;
	logic ld_v = 1'b0;
	logic [1:0] ld_ch = 2'h0;
	logic [11:0] ld_d = 12'h000;
	logic [1:0] ld_m = 2'h0;
	logic scl, m_oe, d_oe, d_out, busy, pd_f;
	logic [1:0] sel;
	logic [8:0] rx;
	int fail_count = 0;
	int compares = 0;
	wire logic sda = ~m_oe & (d_out | ~d_oe);
	// Held words as {mode, data}
	logic [13:0] words [4] = '{14'h0abc, 14'h25a3, 14'h3fff, 14'h1001};
	dirb_row_t rows [4] = '{'{2'h0, 1'b0, 24'habc000}, '{2'h1, 1'b1, 24'hbf5a30},
		'{2'h2, 1'b0, 24'hfff000}, '{2'h3, 1'b1, 24'h7f0010}};
	// ----------------------------------------------------------------
	// Clock, design and far side
	// ----------------------------------------------------------------
	always #25 clk = ~clk;
	dirb_core dut_u (.i_clk(clk), .i_reset_n(rst_n), .i_scl(scl), .i_sda(sda), .o_sda_out(d_out), .o_sda_oe(d_oe),
		.i_hw_address_hi(1'b1), .i_hw_address_lo(1'b0), .i_load_valid(ld_v), .i_load_channel(ld_ch),
		.i_load_data(ld_d), .i_load_mode(ld_m), .o_channel_sel(sel), .o_power_down_flag(pd_f), .o_busy(busy));
	dirb_master_model m_u (.i_clk(clk), .i_sda(sda), .o_scl(scl), .o_sda_oe(m_oe));
	function automatic logic [8:0] adr(input logic rw);
		return {DIRB_ADDR_PREFIX, 2'b10, rw, 1'b1};
	endfunction : adr
	task automatic test_done();
		$display("compares %0d fail_count %0d", compares, fail_count);
		if (fail_count == 0 && compares > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask : test_done
	task automatic load_all();
		for (int c = 0; c < 4; c++) begin
			@(negedge clk);
			ld_v = 1'b1;
			ld_ch = 2'(c);
			{ld_m, ld_d} = words[c];
		end
		@(negedge clk);
		ld_v = 1'b0;
	endtask : load_all
	// Without a stop the next read opens with a repeated start
	task automatic do_read(input dirb_row_t r, input logic fin_stop);
		int n;
		n = r.pd ? 3 : 2;
		m_u.start();
		m_u.xfer(adr(1'b0), rx);
		`CHK("write addr ack", rx[0], 1'b0)
		m_u.xfer({5'h00, r.ch, r.pd, 1'b1}, rx);
		`CHK("control ack", rx[0], 1'b0)
		`CHK("channel select", sel, r.ch)
		`CHK("pd flag", pd_f, r.pd)
		m_u.start();
		m_u.xfer(adr(1'b1), rx);
		`CHK("read addr ack", rx[0], 1'b0)
		`CHK("busy in read", busy, 1'b1)
		for (int k = 0; k < n; k++) begin
			m_u.xfer({8'hff, k == n - 1}, rx);
			`CHK("readback byte", rx[8:1], r.exp[23 - 8 * k -: 8])
		end
		`CHK("nack slot free", rx[0], 1'b1)
		m_u.hold(4);
		`CHK("released after nack", d_oe, 1'b0)
		if (fin_stop) begin
			m_u.stop();
			`CHK("idle after stop", busy, 1'b0)
		end
	endtask : do_read
	// ----------------------------------------------------------------
	// Sequence
	// ----------------------------------------------------------------
	initial begin
		repeat (20) @(negedge clk);
		rst_n = 1'b1;
		m_u.hold(3);
		`CHK("busy after reset", busy, 1'b0)
		do_read('{2'h2, 1'b1, 24'h3f0000}, 1'b0);
		load_all();
		// Second pass shows the reads left the words alone
		for (int p = 0; p < 2; p++) begin
			foreach (rows[i]) begin
				do_read(rows[i], i[0]);
			end
		end
		m_u.start();
		m_u.xfer({DIRB_ADDR_PREFIX, 2'b01, 1'b0, 1'b1}, rx);
		`CHK("foreign addr ack", rx[0], 1'b1)
		m_u.stop();
		// Extra write byte is refused; an acknowledged last byte still ends the read
		m_u.start();
		m_u.xfer(adr(1'b0), rx);
		m_u.xfer({5'h00, 2'h3, 1'b0, 1'b1}, rx);
		m_u.xfer(9'h1ff, rx);
		`CHK("write data refused", rx[0], 1'b1)
		m_u.start();
		m_u.xfer(adr(1'b1), rx);
		for (int k = 0; k < 2; k++) begin
			m_u.xfer(9'h1fe, rx);
			`CHK("acked last byte", rx[8:1], rows[3].exp[15 - 8 * k -: 8])
		end
		m_u.xfer(9'h1ff, rx);
		`CHK("silent after last byte", rx[8:1], 8'hff)
		m_u.stop();
		test_done();
	end
	initial begin
		repeat (90000) @(posedge clk);
		fail_count++;
		test_done();
	end
endmodule : dirb_core_tb
`default_nettype wire
